// ===== rtl/dodt_ctl.sv
// Controller end: AXI4-Lite registers, pin high-time and read spacing.
// Assumes software writes the command address before the command word.
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dodt_ctl
	import dodt_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Pins to the memory
	dodt_if.ctl link,
	// AXI4-Lite write
	input wire logic [7:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [31:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [31:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready
);

	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic do_wr;
	logic want_r;
	logic [15:0] addr_r;
	logic pend_r;
	dodt_cmd_e pcmd_r;
	logic [2:0] pbank_r;
	logic [15:0] paddr_r;
	logic [15:0] mr0_r;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic [3:0] hold_r;
	logic [3:0] hold_dec;
	logic [3:0] hold_wr;
	logic [4:0] low_cnt_r;
	logic [4:0] rd_busy_r;
	logic [4:0] rd_gap;
	logic pin_nxt;
	logic issue;

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [15:0] val, input logic [1:0] strb);
		return {strb[1] ? val[15:8] : old[15:8], strb[0] ? val[7:0] : old[7:0]};
	endfunction : merge16

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	assign do_wr = !o_s_axi_awready && !o_s_axi_wready && !o_s_axi_bvalid;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_s_axi_awready <= 1'b1;
			o_s_axi_wready <= 1'b1;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp <= DODT_RESP_OKAY;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
		end
		else
		begin
			if (i_s_axi_awvalid && o_s_axi_awready)
			begin
				o_s_axi_awready <= 1'b0;
				awaddr_r <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready)
			begin
				o_s_axi_wready <= 1'b0;
				wdata_r <= i_s_axi_wdata;
				wstrb_r <= i_s_axi_wstrb;
			end
			if (do_wr)
			begin
				o_s_axi_bvalid <= 1'b1;
				o_s_axi_bresp <= (awaddr_r == DODT_REG_CTRL ||
					awaddr_r == DODT_REG_CMD || awaddr_r == DODT_REG_ADDR ||
					awaddr_r == DODT_REG_STATUS) ? DODT_RESP_OKAY :
					DODT_RESP_SLVERR;
			end
			if (o_s_axi_bvalid && i_s_axi_bready)
			begin
				o_s_axi_bvalid <= 1'b0;
				o_s_axi_awready <= 1'b1;
				o_s_axi_wready <= 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_s_axi_arready <= 1'b1;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= 32'h00000000;
			o_s_axi_rresp <= DODT_RESP_OKAY;
		end
		else if (i_s_axi_arvalid && o_s_axi_arready)
		begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp <= DODT_RESP_OKAY;
			case (i_s_axi_araddr)
				DODT_REG_CTRL: o_s_axi_rdata <= {31'h0, want_r};
				DODT_REG_CMD: o_s_axi_rdata <= {26'h0, pbank_r, pcmd_r};
				DODT_REG_ADDR: o_s_axi_rdata <= {16'h0, addr_r};
				DODT_REG_STATUS: o_s_axi_rdata <= {27'h0,
					mr1_r[DODT_MR1_DLL_OFF], rd_busy_r != 5'h00,
					hold_r != 4'h0, link.term_control_pin, pend_r};
				default:
				begin
					o_s_axi_rdata <= 32'h00000000;
					o_s_axi_rresp <= DODT_RESP_SLVERR;
				end
			endcase
		end
		else if (o_s_axi_rvalid && i_s_axi_rready)
		begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			want_r <= 1'b0;
			addr_r <= 16'h0000;
		end
		else if (do_wr && awaddr_r == DODT_REG_CTRL && wstrb_r[0])
		begin
			want_r <= wdata_r[0];
		end
		else if (do_wr && awaddr_r == DODT_REG_ADDR)
		begin
			addr_r <= merge16(addr_r, wdata_r[15:0], wstrb_r[1:0]);
		end
	end

	// A command word written while one is pending is dropped
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			pend_r <= 1'b0;
			pcmd_r <= DODT_NOP;
			pbank_r <= 3'h0;
			paddr_r <= 16'h0000;
		end
		else if (issue)
		begin
			pend_r <= 1'b0;
		end
		else if (do_wr && awaddr_r == DODT_REG_CMD && wstrb_r[0] && !pend_r)
		begin
			pend_r <= 1'b1;
			pcmd_r <= dodt_cmd_e'(wdata_r[2:0]);
			pbank_r <= wdata_r[5:3];
			paddr_r <= (wdata_r[2:0] == DODT_MRS &&
				wdata_r[5:3] == DODT_MR2_SEL &&
				mr1_r[DODT_MR1_DLL_OFF]) ?
				{addr_r[15:11], 2'b00, addr_r[8:0]} : addr_r;
		end
	end

	// ------------------------------------------------------------
	// Pin and command sequencing
	// ------------------------------------------------------------
	// Low time needed so termination is gone before read data
	assign rd_gap = (dodt_cwl(mr2_r) > dodt_cl(mr0_r)) ?
		dodt_cwl(mr2_r) - dodt_cl(mr0_r) + 5'h01 : 5'h01;
	assign issue = pend_r && (pcmd_r != DODT_READ ||
		(!link.term_control_pin && low_cnt_r >= rd_gap));
	assign pin_nxt = (link.term_control_pin && hold_r != 4'h0) ||
		(want_r && !(pend_r && pcmd_r == DODT_READ) &&
		rd_busy_r == 5'h00);
	assign hold_dec = (hold_r != 4'h0) ? hold_r - 4'h1 : 4'h0;
	assign hold_wr = (dodt_chop(mr0_r, paddr_r) ? DODT_HIGH_SHORT :
		DODT_HIGH_LONG) - 4'h1;

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			hold_r <= 4'h0;
		end
		else if (pin_nxt && !link.term_control_pin)
		begin
			hold_r <= (issue && pcmd_r == DODT_WRITE &&
				hold_wr > DODT_HIGH_SHORT - 4'h1) ? hold_wr :
				DODT_HIGH_SHORT - 4'h1;
		end
		else if (issue && pcmd_r == DODT_WRITE && pin_nxt)
		begin
			hold_r <= (hold_wr > hold_dec) ? hold_wr : hold_dec;
		end
		else
		begin
			hold_r <= hold_dec;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			low_cnt_r <= 5'h00;
			rd_busy_r <= 5'h00;
		end
		else
		begin
			low_cnt_r <= link.term_control_pin ? 5'h00 :
				(low_cnt_r == 5'h1f ? low_cnt_r : low_cnt_r + 5'h01);
			if (issue && pcmd_r == DODT_READ)
			begin
				rd_busy_r <= dodt_al(mr0_r, mr1_r) + dodt_cl(mr0_r) +
					DODT_RD_TAIL;
			end
			else if (rd_busy_r != 5'h00)
			begin
				rd_busy_r <= rd_busy_r - 5'h01;
			end
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			mr0_r <= DODT_MR_RESET;
			mr1_r <= DODT_MR_RESET;
			mr2_r <= DODT_MR_RESET;
		end
		else if (issue && pcmd_r == DODT_MRS)
		begin
			case (pbank_r)
				DODT_MR0_SEL: mr0_r <= paddr_r;
				DODT_MR1_SEL: mr1_r <= paddr_r;
				DODT_MR2_SEL: mr2_r <= paddr_r;
				default: mr0_r <= mr0_r;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			link.term_control_pin <= 1'b0;
			link.cmd_valid <= 1'b0;
			link.cmd <= DODT_NOP;
			link.bank <= 3'h0;
			link.addr <= 16'h0000;
		end
		else
		begin
			link.term_control_pin <= pin_nxt;
			link.cmd_valid <= issue;
			link.cmd <= issue ? pcmd_r : DODT_NOP;
			link.bank <= pbank_r;
			link.addr <= paddr_r;
		end
	end

endmodule : dodt_ctl
`default_nettype wire

// ===== inc/dodt_pkg.sv
// Shared constants, types and latency helpers for the termination pair.
// Assumes one command clock at 125 MHz shared by controller and memory.
package dodt_pkg;

	// ------------------------------------------------------------
	// Commands and states
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		DODT_NOP = 3'b000,
		DODT_WRITE = 3'b001,
		DODT_READ = 3'b010,
		DODT_MRS = 3'b011,
		DODT_SRE = 3'b100,
		DODT_SRX = 3'b101
	} dodt_cmd_e;

	typedef enum logic [1:0]
	{
		DODT_HIZ = 2'b00,
		DODT_RISE = 2'b01,
		DODT_FULL = 2'b10,
		DODT_FALL = 2'b11
	} dodt_term_st_e;

	// ------------------------------------------------------------
	// Mode register layout
	// ------------------------------------------------------------
	localparam logic [15:0] DODT_MR_RESET = 16'h0000;
	localparam logic [2:0] DODT_MR0_SEL = 3'h0;
	localparam logic [2:0] DODT_MR1_SEL = 3'h1;
	localparam logic [2:0] DODT_MR2_SEL = 3'h2;
	localparam int DODT_MR1_DLL_OFF = 0;
	localparam int DODT_WR_OTF_BIT = 12;
	localparam logic [1:0] DODT_BL_FIXED8 = 2'h0;
	localparam logic [1:0] DODT_BL_OTF = 2'h1;
	localparam logic [1:0] DODT_BL_FIXED4 = 2'h2;
	localparam logic [4:0] DODT_CL_BASE = 5'h04;
	localparam logic [4:0] DODT_CWL_BASE = 5'h05;
	localparam logic [4:0] DODT_LAT_OFFSET = 5'h02;

	// ------------------------------------------------------------
	// Cycle counts
	// ------------------------------------------------------------
	localparam logic [3:0] DODT_HIGH_SHORT = 4'h4;
	localparam logic [3:0] DODT_HIGH_LONG = 4'h6;
	localparam logic [3:0] DODT_STORE_CHOP = 4'h4;
	localparam logic [3:0] DODT_STORE_FULL = 4'h6;
	localparam logic [3:0] DODT_RD_DRIVE = 4'h6;
	localparam logic [4:0] DODT_RD_TAIL = 5'h05;
	localparam int DODT_CLK_PERIOD_PS = 8000;
	localparam int DODT_ON_WIN_MIN_PS = 200;
	localparam int DODT_ON_WIN_MAX_PS = 2000;
	localparam int DODT_OFF_WIN_MIN_PS = 200;
	localparam int DODT_OFF_WIN_MAX_PS = 2000;
	localparam logic [1:0] DODT_LVL_HIZ = 2'h0;
	localparam logic [1:0] DODT_LVL_PART = 2'h1;
	localparam logic [1:0] DODT_LVL_FULL = 2'h2;

	function automatic logic [3:0] dodt_min_cyc(input int ps);
		int c;
		c = (ps + DODT_CLK_PERIOD_PS - 1) / DODT_CLK_PERIOD_PS;
		if (c < 1)
		begin
			c = 1;
		end
		return c[3:0];
	endfunction : dodt_min_cyc

	function automatic logic [3:0] dodt_max_cyc(input int ps);
		int c;
		c = ps / DODT_CLK_PERIOD_PS;
		if (c < 1)
		begin
			c = 1;
		end
		return c[3:0];
	endfunction : dodt_max_cyc

	localparam logic [3:0] DODT_ON_MIN_CYC = dodt_min_cyc(DODT_ON_WIN_MIN_PS);
	localparam logic [3:0] DODT_ON_MAX_CYC = dodt_max_cyc(DODT_ON_WIN_MAX_PS);
	localparam logic [3:0] DODT_OFF_MIN_CYC =
		dodt_min_cyc(DODT_OFF_WIN_MIN_PS);
	localparam logic [3:0] DODT_OFF_MAX_CYC =
		dodt_max_cyc(DODT_OFF_WIN_MAX_PS);

	// ------------------------------------------------------------
	// Register map of the controller
	// ------------------------------------------------------------
	localparam logic [7:0] DODT_REG_CTRL = 8'h00;
	localparam logic [7:0] DODT_REG_CMD = 8'h04;
	localparam logic [7:0] DODT_REG_ADDR = 8'h08;
	localparam logic [7:0] DODT_REG_STATUS = 8'h0c;
	localparam logic [1:0] DODT_RESP_OKAY = 2'b00;
	localparam logic [1:0] DODT_RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// Latency helpers
	// ------------------------------------------------------------
	function automatic logic [4:0] dodt_cl(input logic [15:0] mr0);
		return {2'b00, mr0[6:4]} + DODT_CL_BASE;
	endfunction : dodt_cl

	function automatic logic [4:0] dodt_al(input logic [15:0] mr0,
		input logic [15:0] mr1);
		case (mr1[4:3])
			2'h1: return dodt_cl(mr0) - 5'h01;
			2'h2: return dodt_cl(mr0) - 5'h02;
			default: return 5'h00;
		endcase
	endfunction : dodt_al

	function automatic logic [4:0] dodt_cwl(input logic [15:0] mr2);
		return {2'b00, mr2[5:3]} + DODT_CWL_BASE;
	endfunction : dodt_cwl

	function automatic logic [4:0] dodt_term_lat(input logic [15:0] mr0,
		input logic [15:0] mr1, input logic [15:0] mr2);
		return dodt_al(mr0, mr1) + dodt_cwl(mr2) - DODT_LAT_OFFSET;
	endfunction : dodt_term_lat

	function automatic logic dodt_chop(input logic [15:0] mr0,
		input logic [15:0] addr);
		return (mr0[1:0] == DODT_BL_FIXED4) ||
			((mr0[1:0] == DODT_BL_OTF) && !addr[DODT_WR_OTF_BIT]);
	endfunction : dodt_chop

endpackage : dodt_pkg

// ===== inc/dodt_if.sv
// Command and termination pins from the controller to the memory.
// Assumes both ends run on the same command clock.
`timescale 1ns/1ps
`default_nettype none
interface dodt_if;
	logic term_control_pin;
	logic cmd_valid;
	dodt_pkg::dodt_cmd_e cmd;
	logic [2:0] bank;
	logic [15:0] addr;

	modport dev (input term_control_pin, cmd_valid, cmd, bank, addr);
	modport ctl (output term_control_pin, cmd_valid, cmd, bank, addr);
endinterface : dodt_if
`default_nettype wire

// ===== rtl/dodt_dev.sv
// Memory-side termination control: latency, windows, dynamic strength.
// Assumes the controller keeps the pin high-time and read spacing duties.
`timescale 1ns/1ps
`default_nettype none
module dodt_dev
	import dodt_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Pins from the controller
	dodt_if.dev link,
	// Termination state
	output logic [1:0] o_rtt_level,
	output logic o_rtt_store_sel,
	output logic [2:0] o_rtt_code,
	// Data bus and power state
	output logic o_dq_drive,
	output logic o_self_refresh
);

	logic [15:0] mr0_r;
	logic [15:0] mr1_r;
	logic [15:0] mr2_r;
	logic sr_r;
	logic [31:0] pin_line_r;
	logic [31:0] posted_line_r;
	logic [31:0] wr_line_r;
	logic [31:0] chop_line_r;
	logic [31:0] rd_line_r;
	logic [3:0] store_cnt_r;
	logic [3:0] drive_cnt_r;
	dodt_term_st_e st_r;
	dodt_term_st_e st_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [1:0] lvl_nxt;
	logic [4:0] al;
	logic [4:0] cas_write_latency;
	logic [4:0] lat;
	logic [4:0] rl;
	logic is_write;
	logic is_read;
	logic rtt_enabled;
	logic dyn_enabled;
	logic sync_ok;
	logic posted_pin;
	logic term_req;
	logic store_hit;

	// ------------------------------------------------------------
	// Mode registers and power state
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			mr0_r <= DODT_MR_RESET;
			mr1_r <= DODT_MR_RESET;
			mr2_r <= DODT_MR_RESET;
		end
		else if (link.cmd_valid && link.cmd == DODT_MRS)
		begin
			case (link.bank)
				DODT_MR0_SEL: mr0_r <= link.addr;
				DODT_MR1_SEL: mr1_r <= link.addr;
				DODT_MR2_SEL: mr2_r <= link.addr;
				default: mr0_r <= mr0_r;
			endcase
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			sr_r <= 1'b0;
		end
		else if (link.cmd_valid && link.cmd == DODT_SRE)
		begin
			sr_r <= 1'b1;
		end
		else if (link.cmd_valid && link.cmd == DODT_SRX)
		begin
			sr_r <= 1'b0;
		end
	end

	assign al = dodt_al(mr0_r, mr1_r);
	assign cas_write_latency = dodt_cwl(mr2_r);
	assign lat = dodt_term_lat(mr0_r, mr1_r, mr2_r);
	assign rl = al + dodt_cl(mr0_r);
	assign is_write = link.cmd_valid && link.cmd == DODT_WRITE;
	assign is_read = link.cmd_valid && link.cmd == DODT_READ;
	assign rtt_enabled = mr1_r[9] || mr1_r[6] || mr1_r[2] ||
		mr2_r[10] || mr2_r[9];
	assign dyn_enabled = mr2_r[10] || mr2_r[9];
	assign sync_ok = !sr_r && !mr1_r[DODT_MR1_DLL_OFF];

	// ------------------------------------------------------------
	// Latency lines
	// ------------------------------------------------------------
	// Index 0 holds the value registered at the last edge
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n || sr_r)
		begin
			pin_line_r <= 32'h00000000;
			posted_line_r <= 32'h00000000;
			wr_line_r <= 32'h00000000;
			chop_line_r <= 32'h00000000;
			rd_line_r <= 32'h00000000;
		end
		else
		begin
			pin_line_r <= {pin_line_r[30:0], link.term_control_pin};
			posted_line_r <= {posted_line_r[30:0], posted_pin};
			wr_line_r <= {wr_line_r[30:0], is_write};
			chop_line_r <= {chop_line_r[30:0], dodt_chop(mr0_r, link.addr)};
			rd_line_r <= {rd_line_r[30:0], is_read};
		end
	end

	assign posted_pin = pin_line_r[al];
	assign term_req = posted_line_r[cas_write_latency - 5'h03] && rtt_enabled &&
		sync_ok && (drive_cnt_r == 4'h0);
	assign store_hit = wr_line_r[lat - 5'h01] && dyn_enabled;

	// ------------------------------------------------------------
	// Read data drive window
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n || sr_r)
		begin
			drive_cnt_r <= 4'h0;
		end
		else if (rd_line_r[rl - 5'h02])
		begin
			drive_cnt_r <= DODT_RD_DRIVE;
		end
		else if (drive_cnt_r != 4'h0)
		begin
			drive_cnt_r <= drive_cnt_r - 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Dynamic strength selection
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n || sr_r)
		begin
			store_cnt_r <= 4'h0;
		end
		else if (store_hit)
		begin
			store_cnt_r <= chop_line_r[lat - 5'h01] ?
				DODT_STORE_CHOP : DODT_STORE_FULL;
		end
		else if (store_cnt_r != 4'h0)
		begin
			store_cnt_r <= store_cnt_r - 4'h1;
		end
	end

	// ------------------------------------------------------------
	// Turn-on and turn-off windows
	// ------------------------------------------------------------
	always_comb
	begin
		st_nxt = st_r;
		cnt_nxt = cnt_r + 4'h1;
		case (st_r)
			DODT_HIZ:
			begin
				cnt_nxt = 4'h1;
				if (term_req)
				begin
					st_nxt = DODT_RISE;
				end
			end
			DODT_RISE:
			begin
				if (!term_req)
				begin
					st_nxt = DODT_FALL;
					cnt_nxt = 4'h1;
				end
			end
			DODT_FULL:
			begin
				cnt_nxt = 4'h1;
				if (!term_req)
				begin
					st_nxt = DODT_FALL;
				end
			end
			DODT_FALL:
			begin
				if (term_req)
				begin
					st_nxt = DODT_RISE;
					cnt_nxt = 4'h1;
				end
			end
			default:
			begin
				st_nxt = DODT_HIZ;
				cnt_nxt = 4'h0;
			end
		endcase
		if (st_nxt == DODT_RISE && cnt_nxt >= DODT_ON_MAX_CYC)
		begin
			st_nxt = DODT_FULL;
		end
		if (st_nxt == DODT_FALL && cnt_nxt >= DODT_OFF_MAX_CYC)
		begin
			st_nxt = DODT_HIZ;
		end
		case (st_nxt)
			DODT_RISE: lvl_nxt = (cnt_nxt >= DODT_ON_MIN_CYC) ?
				DODT_LVL_PART : DODT_LVL_HIZ;
			DODT_FALL: lvl_nxt = (cnt_nxt >= DODT_OFF_MIN_CYC) ?
				DODT_LVL_PART : DODT_LVL_FULL;
			DODT_FULL: lvl_nxt = DODT_LVL_FULL;
			default: lvl_nxt = DODT_LVL_HIZ;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			st_r <= DODT_HIZ;
			cnt_r <= 4'h0;
			o_rtt_level <= DODT_LVL_HIZ;
		end
		else
		begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			o_rtt_level <= lvl_nxt;
		end
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			o_rtt_store_sel <= 1'b0;
			o_rtt_code <= 3'h0;
			o_dq_drive <= 1'b0;
			o_self_refresh <= 1'b0;
		end
		else
		begin
			o_rtt_store_sel <= store_hit || store_cnt_r > 4'h1;
			o_rtt_code <= (store_hit || store_cnt_r > 4'h1) ?
				{1'b0, mr2_r[10:9]} :
				{mr1_r[9], mr1_r[6], mr1_r[2]};
			o_dq_drive <= rd_line_r[rl - 5'h02] || drive_cnt_r > 4'h1;
			o_self_refresh <= sr_r;
		end
	end

endmodule : dodt_dev
`default_nettype wire

// ===== verif/dodt_sva.sv
// Concurrent checks on the termination link and the memory outputs.
// Assumes default latencies: additive latency 0, write latency 5.
`timescale 1ns/1ps
`default_nettype none
module dodt_sva
	import dodt_pkg::*;
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// Link from the controller
	input wire logic term_control_pin,
	input wire logic cmd_valid,
	input var dodt_cmd_e cmd,
	// Memory termination state
	input wire logic [1:0] o_rtt_level,
	input wire logic o_rtt_store_sel,
	input wire logic [2:0] o_rtt_code,
	input wire logic o_dq_drive,
	input wire logic o_self_refresh
);
	logic wr_cmd;
	logic rd_cmd;
	assign wr_cmd = cmd_valid && (cmd == DODT_WRITE);
	assign rd_cmd = cmd_valid && (cmd == DODT_READ);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_hold_high;
		$rose(term_control_pin) |-> term_control_pin[*4];
	endproperty
	a_hold_high: assert property (p_hold_high)
		else $error("pin dropped before minimum high time");
	property p_wr_hold;
		wr_cmd && term_control_pin |-> term_control_pin[*4];
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("pin dropped too soon after write");
	property p_on_lat;
		o_rtt_level == DODT_LVL_FULL |-> $past(term_control_pin, 5);
	endproperty
	a_on_lat: assert property (p_on_lat)
		else $error("termination on without pin five cycles before");
	property p_store_lat;
		$rose(o_rtt_store_sel) |-> $past(wr_cmd, 4);
	endproperty
	a_store_lat: assert property (p_store_lat)
		else $error("write strength without write four cycles before");
	property p_rd_low;
		rd_cmd |-> !term_control_pin;
	endproperty
	a_rd_low: assert property (p_rd_low)
		else $error("read issued with pin high");
	property p_dq_noterm;
		o_dq_drive |-> o_rtt_level == DODT_LVL_HIZ && !term_control_pin;
	endproperty
	a_dq_noterm: assert property (p_dq_noterm)
		else $error("termination while driving data");
	property p_sr_off;
		o_self_refresh[*3] |-> o_rtt_level == DODT_LVL_HIZ;
	endproperty
	a_sr_off: assert property (p_sr_off)
		else $error("termination on in self refresh");
	property p_code;
		o_rtt_store_sel |-> !o_rtt_code[2] && o_rtt_code[1:0] != 2'h0;
	endproperty
	a_code: assert property (p_code)
		else $error("write strength code out of range");
endmodule : dodt_sva
`default_nettype wire

// ===== verif/testbench.sv
// Bench joining controller and memory through the termination link.
// Assumes default latencies after reset: additive 0, write latency 5.
`timescale 1ns/1ps
`default_nettype none
module testbench
	import dodt_pkg::*;
;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] e;
		logic [31:0] q;} dodt_row_s;
	logic i_clk = 1'h0;
	logic i_reset_n = 1'h0;
	logic [7:0] i_s_axi_awaddr = 8'h00;
	logic [7:0] i_s_axi_araddr = 8'h00;
	logic [31:0] i_s_axi_wdata = 32'h0;
	logic [3:0] i_s_axi_wstrb = 4'hf;
	logic i_s_axi_awvalid = 1'h0;
	logic i_s_axi_wvalid = 1'h0;
	logic i_s_axi_arvalid = 1'h0;
	logic i_s_axi_bready = 1'h1;
	logic i_s_axi_rready = 1'h1;
	logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
	logic o_s_axi_arready, o_s_axi_rvalid, o_rtt_store_sel;
	logic o_dq_drive, o_self_refresh;
	logic [1:0] o_s_axi_bresp, o_s_axi_rresp, o_rtt_level;
	logic [2:0] o_rtt_code;
	logic [31:0] o_s_axi_rdata;
	int error_cnt = 0;
	int compares = 0;
	dodt_row_s rows [3] = '{
		'{DODT_REG_ADDR, 32'h0000a5c3, DODT_RESP_OKAY, 32'h0000a5c3},
		'{DODT_REG_CTRL, 32'h0, DODT_RESP_OKAY, 32'h0},
		'{8'h10, 32'h1, DODT_RESP_SLVERR, 32'h0}};
	logic [15:0] mr0 [3] = '{16'h0000, 16'h0001, 16'h0001};
	logic [15:0] wa [3] = '{16'h0000, 16'h0000, 16'h1000};
	logic [3:0] len [3] = '{DODT_STORE_FULL, DODT_STORE_CHOP,
		DODT_STORE_FULL};

	dodt_if link();
	dodt_ctl dodt_ctl_inst (.i_clk, .i_reset_n, .link, .i_s_axi_awaddr,
		.i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wdata, .i_s_axi_wstrb,
		.i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
		.i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
		.o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid,
		.i_s_axi_rready);
	dodt_dev dodt_dev_inst (.i_clk, .i_reset_n, .link, .o_rtt_level,
		.o_rtt_store_sel, .o_rtt_code, .o_dq_drive, .o_self_refresh);
	dodt_sva dodt_sva_inst (.i_clk, .i_reset_n,
		.term_control_pin(link.term_control_pin),
		.cmd_valid(link.cmd_valid), .cmd(link.cmd), .o_rtt_level,
		.o_rtt_store_sel, .o_rtt_code, .o_dq_drive, .o_self_refresh);

	always #4 i_clk = ~i_clk;

	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic conclude;
		if (error_cnt == 0 && compares > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(inout int n);
		@(posedge i_clk);
		n++;
		if (n > 400)
		begin
			error_cnt++;
			$display("CHECK FAILED %0t wait timed out", $time);
			conclude();
		end
	endtask : tick

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		i_s_axi_awaddr <= a;
		i_s_axi_wdata <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid <= 1'h1;
		do
		begin
			tick(n);
			if (o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
			if (o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
		end
		while (!o_s_axi_bvalid);
		r = o_s_axi_bresp;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		i_s_axi_araddr <= a;
		i_s_axi_arvalid <= 1'h1;
		do
		begin
			tick(n);
			if (o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
		end
		while (!o_s_axi_rvalid);
		d = o_s_axi_rdata;
		r = o_s_axi_rresp;
	endtask : rd

	task automatic issue(input logic [15:0] a, input logic [2:0] bk,
		input dodt_cmd_e c);
		logic [1:0] r;
		int n;
		n = 0;
		wr(DODT_REG_ADDR, {16'h0, a}, r);
		wr(DODT_REG_CMD, {26'h0, bk, c}, r);
		while (!(link.cmd_valid && link.cmd == c)) tick(n);
	endtask : issue

	task automatic pin(input logic v, input logic [1:0] lv);
		logic [1:0] r;
		int n;
		n = 0;
		wr(DODT_REG_CTRL, {31'h0, v}, r);
		while (o_rtt_level !== lv) tick(n);
	endtask : pin

	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		logic [1:0] r;
		logic [31:0] q;
		int n;
		repeat (4) @(posedge i_clk);
		i_reset_n <= 1'h1;
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, r);
			chk(r, rows[i].e);
			rd(rows[i].a, q, r);
			chk(r, rows[i].e);
			chk(q, rows[i].q);
		end
		issue(16'h0004, DODT_MR1_SEL, DODT_MRS);
		issue(16'h0400, DODT_MR2_SEL, DODT_MRS);
		pin(1'h1, DODT_LVL_FULL);
		chk(o_rtt_code, 3'h1);
		for (int j = 0; j < 3; j++)
		begin
			issue(mr0[j], DODT_MR0_SEL, DODT_MRS);
			issue(wa[j], 3'h0, DODT_WRITE);
			n = 0;
			while (!o_rtt_store_sel) tick(n);
			chk(o_rtt_code, 3'h2);
			n = 0;
			while (o_rtt_store_sel) tick(n);
			chk(n, len[j]);
			chk(o_rtt_code, 3'h1);
		end
		pin(1'h0, DODT_LVL_HIZ);
		pin(1'h1, DODT_LVL_FULL);
		issue(16'h0, 3'h0, DODT_READ);
		n = 0;
		while (!o_dq_drive) tick(n);
		n = 0;
		while (o_dq_drive) tick(n);
		chk(n, DODT_RD_DRIVE);
		n = 0;
		while (o_rtt_level !== DODT_LVL_FULL) tick(n);
		issue(16'h0, 3'h0, DODT_SRE);
		n = 0;
		while (!o_self_refresh) tick(n);
		repeat (3) @(posedge i_clk);
		chk(o_rtt_level, DODT_LVL_HIZ);
		issue(16'h0, 3'h0, DODT_SRX);
		pin(1'h1, DODT_LVL_FULL);
		i_reset_n <= 1'h0;
		repeat (2) @(posedge i_clk);
		chk({o_rtt_level, o_s_axi_bvalid, o_s_axi_awready}, 4'h1);
		i_reset_n <= 1'h1;
		wr(DODT_REG_CTRL, 32'h1, r);
		repeat (8) @(posedge i_clk);
		chk(o_rtt_level, DODT_LVL_HIZ);
		conclude();
	end
endmodule : testbench
`default_nettype wire
